// file: dv/pbsr_basic_status_tb.sv
// Purpose: random self-checking bench of the basic status register
// Assumes: inputs move on the falling edge; outputs compared there too
// Notes:   a reference of the flags runs beside the design on the rising edge
module pbsr_basic_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pbsr_pkg::*;
  logic CLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic CE_I = 1'b0;
  pbsr_evt_t EVT_I = '0;
  logic RD_STB_I, PRE_DONE_I, FRAME_BAD_I, NEED_PREAMBLE_O;
  logic [4:0] RD_ADDR_I;
  pbsr_rsp_t RSP_O, rsp_e;
  logic [7:0] rnd = 8'h00;
  logic an_e, rf_e, link_e, jab_e, need_e, run = 1'b0;
  integer seed = 28;
  integer r;
  int fail_count = 0;
  int compares = 0;
  always #4 CLK_I = ~CLK_I;
  pbsr_basic_status dut_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .EVT_I(EVT_I),
    .RD_STB_I(RD_STB_I), .RD_ADDR_I(RD_ADDR_I), .PRE_DONE_I(PRE_DONE_I),
    .FRAME_BAD_I(FRAME_BAD_I), .RSP_O(RSP_O), .NEED_PREAMBLE_O(NEED_PREAMBLE_O));
  pbsr_mgmt_model mgmt_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .RND_I(rnd),
    .RD_STB_O(RD_STB_I), .RD_ADDR_O(RD_ADDR_I), .PRE_DONE_O(PRE_DONE_I),
    .FRAME_BAD_O(FRAME_BAD_I));
  function automatic logic [15:0] word_of(logic an, logic rf, logic ln, logic jb);
    return 16'h7949 | {10'h000, an, rf, 1'b0, ln, jb, 1'b0};
  endfunction : word_of
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d, fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // reference of the documented flags; set wins over release in the read cycle
  always @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      {an_e, rf_e, link_e, jab_e} <= 4'h0;
      rsp_e  <= '0;
      need_e <= 1'b1;
    end
    else if (CE_I)
    begin
      an_e <= EVT_I.an_done;
      rsp_e.valid <= RD_STB_I;
      rsp_e.data  <= (RD_STB_I && RD_ADDR_I == 5'h01) ? word_of(an_e, rf_e, link_e, jab_e) : '0;
      if (RD_STB_I && RD_ADDR_I == 5'h01)
      begin
        rf_e   <= EVT_I.far_end_fault | EVT_I.rf_notify;
        jab_e  <= EVT_I.jabber & EVT_I.speed_10;
        link_e <= EVT_I.link_good;
      end
      else
      begin
        rf_e   <= rf_e | EVT_I.far_end_fault | EVT_I.rf_notify;
        jab_e  <= jab_e | (EVT_I.jabber & EVT_I.speed_10);
        link_e <= link_e & EVT_I.link_good;
      end
      need_e <= FRAME_BAD_I | (need_e & !PRE_DONE_I);
    end
  end
  always @(negedge CLK_I)
  begin
    if (run)
    begin
      chk({1'b0, RSP_O.data & 16'hFFC9}, {1'b0, rsp_e.data & 16'hFFC9});
      chk(RSP_O, rsp_e);
      chk({16'h0000, NEED_PREAMBLE_O}, {16'h0000, need_e});
    end
    r = $random(seed);
    rnd   <= r[7:0];
    CE_I  <= r[11:8] != 4'h0;
    // events are sparse so latched flags are seen both set and released
    EVT_I <= '{an_done: r[12], link_good: r[15:13] != 3'h0, far_end_fault: r[18:16] == 3'h0,
               rf_notify: r[21:19] == 3'h0, jabber: r[23:22] == 2'h0, speed_10: r[24]};
  end
  initial
  begin
    repeat (5) @(posedge CLK_I);
    @(negedge CLK_I);
    RESET_I <= 1'b0;
    run <= 1'b1;
    repeat (1500) @(negedge CLK_I);
    // second reset in mid-run must drop every latch again
    RESET_I <= 1'b1;
    repeat (3) @(negedge CLK_I);
    RESET_I <= 1'b0;
    repeat (1500) @(negedge CLK_I);
    tally_and_finish();
  end
  initial
  begin
    #40000;
    fail_count++;
    tally_and_finish();
  end
endmodule : pbsr_basic_status_tb

// file: dv/pbsr_mgmt_model.sv
// Purpose: management controller model that issues register reads and preamble events
// Assumes: RND_I changes by non-blocking assignment on the falling edge
// Notes:   about half of reads target the status register so the latches get exercised
module pbsr_mgmt_model
(
  input  wire logic       CLK_I,
  input  wire logic       RESET_I,
  input  wire logic       CE_I,
  input  wire logic [7:0] RND_I,
  output logic            RD_STB_O,
  output logic [4:0]      RD_ADDR_O,
  output logic            PRE_DONE_O,
  output logic            FRAME_BAD_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic need_q;
  logic took_pre;
  logic pend;
  logic bad;
  logic go;
  // no write frames are sent, so reserved bit 7 is never written with one
  always @(negedge CLK_I)
  begin
    // a preamble sent while the device was frozen or with a bad frame does not count
    took_pre = PRE_DONE_O && !FRAME_BAD_O && CE_I;
    pend     = need_q && !took_pre;
    bad      = !RESET_I && RND_I[7:3] == 5'h00;
    go       = !RESET_I && !bad && RND_I[1:0] != 2'h0;
    RD_ADDR_O   <= RND_I[2] ? RND_I[7:3] : 5'h01;
    FRAME_BAD_O <= bad;
    // a full preamble goes out before the first read after reset or a bad frame;
    // sometimes it rides along with the bad frame, which must still win
    PRE_DONE_O  <= go ? pend : (bad && RND_I[2]);
    RD_STB_O    <= go && !pend;
    need_q      <= RESET_I || bad || pend;
  end
endmodule : pbsr_mgmt_model

// file: logic/pbsr_basic_status.sv
// Purpose: basic mode status register with latched fault, link and jabber flags
// Assumes: event inputs and read strobe come from logic on CLK_I
// Notes:   the serial frame engine sits outside and presents one-cycle read strobes
module pbsr_basic_status
(
  input  wire logic                   CLK_I,
  input  wire logic                   RESET_I,
  input  wire logic                   CE_I,
  input  wire pbsr_pkg::pbsr_evt_t    EVT_I,
  input  wire logic                   RD_STB_I,
  input  wire logic [4:0]             RD_ADDR_I,
  input  wire logic                   PRE_DONE_I,
  input  wire logic                   FRAME_BAD_I,
  output pbsr_pkg::pbsr_rsp_t         RSP_O,
  output logic                        NEED_PREAMBLE_O
);
  import pbsr_pkg::*;

  logic        rd_hit;
  logic        rf_evt;
  logic        jab_evt;

  logic        an_q;
  logic        an_d;
  logic        rf_q;
  logic        rf_d;
  logic        link_q;
  logic        link_d;
  logic        jab_q;
  logic        jab_d;
  pbsr_rsp_t   rsp_q;
  pbsr_rsp_t   rsp_d;

  pbsr_pre_t   pre_q;
  pbsr_pre_t   pre_d;
  logic        need_pre_q;
  logic        need_pre_d;

  function automatic logic [15:0] compose_status
  (
    input logic an,
    input logic rf,
    input logic link,
    input logic jab
  );
    logic [15:0] v;
    v                   = FIXED_VAL;
    v[BIT_AN_DONE]      = an;
    v[BIT_REMOTE_FAULT] = rf;
    v[BIT_LINK]         = link;
    v[BIT_JABBER]       = jab;
    return v;
  endfunction : compose_status

  function automatic logic addr_is_status
  (
    input logic [4:0] a
  );
    return a == BASIC_STATUS_ADDR;
  endfunction : addr_is_status

  // status flags
  always_comb
  begin
    rd_hit  = RD_STB_I && addr_is_status(RD_ADDR_I);
    rf_evt  = EVT_I.far_end_fault | EVT_I.rf_notify;
    // jabber outside 10 Mbps is ignored so bit 1 never reflects a stale state
    jab_evt = EVT_I.jabber & EVT_I.speed_10;
    an_d    = EVT_I.an_done;
    // a new event in the read cycle wins over the release
    rf_d    = rf_evt | (rf_q & ~rd_hit);
    jab_d   = jab_evt | (jab_q & ~rd_hit);
    // low latch: a failure drops it, only a read lets a good link back in
    link_d  = rd_hit ? EVT_I.link_good : (link_q & EVT_I.link_good);
    rsp_d.valid = RD_STB_I;
    // fixed capability and reserved bits come from the constant pattern
    rsp_d.data  = rd_hit ? compose_status(an_q, rf_q, link_q, jab_q)
                         : 16'h0000;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      an_q   <= AN_DONE_RST;
      rf_q   <= REMOTE_FAULT_RST;
      link_q <= LINK_RST;
      jab_q  <= JABBER_RST;
      rsp_q  <= '0;
    end
    else if (CE_I)
    begin
      an_q   <= an_d;
      rf_q   <= rf_d;
      link_q <= link_d;
      jab_q  <= jab_d;
      rsp_q  <= rsp_d;
    end
  end

  // preamble tracking: the frame engine asks whether a full preamble is due
  always_comb
  begin
    case (pre_q)
      PRE_WAIT:
      begin
        pre_d = (PRE_DONE_I && !FRAME_BAD_I) ? PRE_OK : PRE_WAIT;
      end
      PRE_OK:
      begin
        // bad opcode or turnaround forces one more full preamble
        pre_d = FRAME_BAD_I ? PRE_WAIT : PRE_OK;
      end
      default:
      begin
        pre_d = PRE_WAIT;
      end
    endcase
    need_pre_d = (pre_d == PRE_WAIT);
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      pre_q      <= PRE_WAIT;
      need_pre_q <= NEED_PRE_RST;
    end
    else if (CE_I)
    begin
      pre_q      <= pre_d;
      need_pre_q <= need_pre_d;
    end
  end

  assign RSP_O           = rsp_q;
  assign NEED_PREAMBLE_O = need_pre_q;

  a_fixed_bits_read: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> ((RSP_O.data & FIXED_MASK) == FIXED_VAL) && RSP_O.valid
  ) else $error("fixed capability bits wrong on status read");

  a_speed_caps_one: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_TX_FD] && RSP_O.data[BIT_TX_HD]
                       && RSP_O.data[BIT_TE_FD] && RSP_O.data[BIT_TE_HD]
  ) else $error("speed capability bits not one");

  a_t2_t4_zero: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> !RSP_O.data[BIT_T4] && !RSP_O.data[BIT_T2_FD]
                       && !RSP_O.data[BIT_T2_HD]
  ) else $error("unsupported mode bits not zero");

  a_rsvd_bit_zero: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    RSP_O.valid |-> !RSP_O.data[BIT_RSVD]
  ) else $error("reserved bit reads one");

  a_ability_bits: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_PRE_SUPP] && RSP_O.data[BIT_AN_ABLE]
                       && RSP_O.data[BIT_EXT_STATUS] && RSP_O.data[BIT_EXT_CAP]
  ) else $error("ability bits not one");

  a_an_done_shown: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && EVT_I.an_done ##1 CE_I && rd_hit |=> RSP_O.data[BIT_AN_DONE]
  ) else $error("negotiation done not reported");

  a_rf_sets: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && (EVT_I.far_end_fault || EVT_I.rf_notify) |=> rf_q
  ) else $error("remote fault not latched");

  a_rf_holds: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    rf_q && !(CE_I && rd_hit) |=> rf_q
  ) else $error("remote fault dropped without a read");

  a_rf_release: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit && !rf_evt |=> !rf_q ##0 RSP_O.data[BIT_REMOTE_FAULT] == $past(rf_q)
  ) else $error("remote fault not released after read");

  a_link_fail: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && !EVT_I.link_good |=> !link_q
  ) else $error("link bit kept after failure");

  a_link_no_rise: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    !link_q && !(CE_I && rd_hit) |=> !link_q
  ) else $error("link bit rose without a read");

  a_link_read_rise: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit && EVT_I.link_good |=> link_q ##0 RSP_O.data[BIT_LINK] == $past(link_q)
  ) else $error("link bit wrong after read with good link");

  a_jab_only_10m: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && !jab_q && !(EVT_I.jabber && EVT_I.speed_10) |=> !jab_q
  ) else $error("jabber set outside 10 Mbps");

  a_jab_latch: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && EVT_I.jabber && EVT_I.speed_10 |=> jab_q ##1 (jab_q || $past(CE_I && rd_hit))
  ) else $error("jabber latch not held");

  a_unmapped_zero: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && RD_STB_I && !rd_hit |=> RSP_O.valid && RSP_O.data == 16'h0000
  ) else $error("other address did not read zero");

  a_pre_bad_frame: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && FRAME_BAD_I |=> NEED_PREAMBLE_O
  ) else $error("bad frame did not demand a preamble");

  a_pre_accept: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && NEED_PREAMBLE_O && PRE_DONE_I && !FRAME_BAD_I |=> !NEED_PREAMBLE_O
  ) else $error("full preamble not accepted");

  a_freeze_hold: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    !CE_I |=> $stable(rf_q) && $stable(link_q) && $stable(jab_q) && $stable(RSP_O)
  ) else $error("state moved with clock enable low");

  // read port: every taken strobe answers once, and nothing else answers
  a_read_answered: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && RD_STB_I |=> RSP_O.valid
  ) else $error("read strobe got no answer");

  a_idle_quiet: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && !RD_STB_I |=> !RSP_O.valid && RSP_O.data == 16'h0000
  ) else $error("answer without a read strobe");

  // one check per fixed field, so a broken constant names its own rule
  a_t4_bit_zero: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    RSP_O.valid |-> !RSP_O.data[BIT_T4]
  ) else $error("four-pair mode bit reads one");

  a_tx_caps_one: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_TX_FD] && RSP_O.data[BIT_TX_HD]
  ) else $error("100 Mbps capability bits not one");

  a_te_caps_one: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_TE_FD] && RSP_O.data[BIT_TE_HD]
  ) else $error("10 Mbps capability bits not one");

  a_t2_caps_zero: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    RSP_O.valid |-> !RSP_O.data[BIT_T2_FD] && !RSP_O.data[BIT_T2_HD]
  ) else $error("two-pair mode bits read one");

  a_ext_status_one: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_EXT_STATUS]
  ) else $error("extended status bit not one");

  a_pre_supp_one: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_PRE_SUPP]
  ) else $error("preamble suppression bit not one");

  a_an_able_one: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_AN_ABLE]
  ) else $error("negotiation ability bit not one");

  a_ext_cap_one: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_EXT_CAP]
  ) else $error("extended capability bit not one");

  a_an_done_zero: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && !EVT_I.an_done |=> !an_q
  ) else $error("negotiation done shown while not done");

  a_an_done_read: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_AN_DONE] == $past(an_q)
  ) else $error("negotiation done read wrong");

  a_rf_read_value: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_REMOTE_FAULT] == $past(rf_q)
  ) else $error("remote fault read wrong");

  a_rf_read_set: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit && rf_evt |=> rf_q
  ) else $error("fault in read cycle was lost");

  a_rf_no_rise: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    !rf_q && !(CE_I && rf_evt) |=> !rf_q
  ) else $error("remote fault set without a fault");

  a_jab_read_value: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_JABBER] == $past(jab_q)
  ) else $error("jabber read wrong");

  a_jab_release: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit && !jab_evt |=> !jab_q
  ) else $error("jabber not released after read");

  a_jab_holds: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    jab_q && !(CE_I && rd_hit) |=> jab_q
  ) else $error("jabber dropped without a read");

  a_link_read_value: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && rd_hit |=> RSP_O.data[BIT_LINK] == $past(link_q)
  ) else $error("link bit read wrong");

  a_link_good_holds: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    link_q && CE_I && EVT_I.link_good |=> link_q
  ) else $error("link bit dropped on a good link");

  // the tracker must not move except on the two frame events
  a_pre_holds_ok: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    !NEED_PREAMBLE_O && !(CE_I && FRAME_BAD_I) |=> !NEED_PREAMBLE_O
  ) else $error("preamble demanded without a bad frame");

  a_pre_holds_wait: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    NEED_PREAMBLE_O && !(CE_I && PRE_DONE_I && !FRAME_BAD_I) |=> NEED_PREAMBLE_O
  ) else $error("preamble demand dropped without a preamble");

  a_freeze_flags: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    !CE_I |=> $stable(an_q) && $stable(NEED_PREAMBLE_O)
  ) else $error("done or preamble state moved with clock enable low");

endmodule : pbsr_basic_status

// file: logic/pbsr_pkg.sv
// Purpose: constants and types of the basic status register block
// Assumes: one 125 MHz clock, synchronous active-high reset
package pbsr_pkg;

  localparam logic [4:0]  BASIC_STATUS_ADDR = 5'h01;
  localparam int          REG_W             = 16;
  localparam int          ADDR_W            = 5;

  localparam int          BIT_T4            = 15;
  localparam int          BIT_TX_FD         = 14;
  localparam int          BIT_TX_HD         = 13;
  localparam int          BIT_TE_FD         = 12;
  localparam int          BIT_TE_HD         = 11;
  localparam int          BIT_T2_FD         = 10;
  localparam int          BIT_T2_HD         = 9;
  localparam int          BIT_EXT_STATUS    = 8;
  localparam int          BIT_RSVD          = 7;
  localparam int          BIT_PRE_SUPP      = 6;
  localparam int          BIT_AN_DONE       = 5;
  localparam int          BIT_REMOTE_FAULT  = 4;
  localparam int          BIT_AN_ABLE       = 3;
  localparam int          BIT_LINK          = 2;
  localparam int          BIT_JABBER        = 1;
  localparam int          BIT_EXT_CAP       = 0;

  // bits that never change, and the values they carry
  localparam logic [15:0] FIXED_MASK        = 16'hFFC9;
  localparam logic [15:0] FIXED_VAL         = 16'h7949;

  localparam logic        AN_DONE_RST       = 1'b0;
  localparam logic        REMOTE_FAULT_RST  = 1'b0;
  localparam logic        LINK_RST          = 1'b0;
  localparam logic        JABBER_RST        = 1'b0;
  localparam logic        NEED_PRE_RST      = 1'b1;

  typedef struct packed {
    logic an_done;
    logic link_good;
    logic far_end_fault;
    logic rf_notify;
    logic jabber;
    logic speed_10;
  } pbsr_evt_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } pbsr_rsp_t;

  typedef enum logic [1:0] {
    PRE_WAIT = 2'b00,
    PRE_OK   = 2'b01
  } pbsr_pre_t;

endpackage : pbsr_pkg
